// ---- bench/rtes_event_status_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtes_event_status_sva #(
   parameter ADDR_W = 8
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic update_end_i,
   input wire logic alarm_match_i,
   input wire logic periodic_tick_i,
   input wire logic backup_ok_i,
   input wire logic buffer_copy_en_o,
   input wire logic irq_n_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   wire logic rd_c = reg_rd_i && reg_addr_i == 8'h0c;
   wire logic quiet = !(alarm_match_i || periodic_tick_i || update_end_i);
   a_event_zeros: assert property (
      rd_c |=> reg_rdata_o[3] == 1'b0 && reg_rdata_o[1:0] == 2'h0)
      else $error("event status spare bits set");
   a_integ_value: assert property (
      reg_rd_i && reg_addr_i == 8'h0d |=>
      reg_rdata_o == {$past(backup_ok_i), 7'h00})
      else $error("integrity status value wrong");
   a_alarm_seen: assert property (
      alarm_match_i ##1 !rd_c ##1 rd_c |=> reg_rdata_o[5])
      else $error("alarm flag not reported");
   a_read_clears: assert property (
      rd_c && quiet ##1 quiet ##1 rd_c && quiet |=> reg_rdata_o[7:4] == 4'h0)
      else $error("flags survived a read");
   a_irq_matches: assert property (
      rd_c |=> reg_rdata_o[7] != $past(irq_n_o))
      else $error("request flag and pin disagree");
   a_irq_release: assert property (
      rd_c && quiet |=> irq_n_o)
      else $error("interrupt pin not released");
   a_inhibit_copy: assert property (
      reg_wr_i && reg_addr_i == 8'h0b |=>
      buffer_copy_en_o == !$past(reg_wdata_i[7]))
      else $error("copy enable wrong after control write");
   a_pending_held: assert property (
      !buffer_copy_en_o && reg_rd_i && reg_addr_i == 8'h0a |=> !reg_rdata_o[7])
      else $error("update pending under inhibit");
endmodule
bind rtes_event_status rtes_event_status_sva #(.ADDR_W(ADDR_W))
   rtes_event_status_sva_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .update_end_i(update_end_i), .alarm_match_i(alarm_match_i),
   .periodic_tick_i(periodic_tick_i), .backup_ok_i(backup_ok_i),
   .buffer_copy_en_o(buffer_copy_en_o), .irq_n_o(irq_n_o));
`default_nettype wire

// ---- bench/rtes_event_status_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtes_event_status_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr, wd, rdata;
   logic wr_s, rd_s, copy_en, pin, irq_n, rd_d = 1'b0;
   logic osc_run, div_run, pe;
   logic [3:0] rsel;
   logic ok = 1'b1, ow = 1'b0, rw = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [7:0] exp_q[$];
   string nm_q[$];
   integer miscompares = 0, num_checks = 0, seed = 32'h7465, i;
   initial forever #20 clk = ~clk;
   rtes_host_model rtes_host_model_i (.clk_i(clk), .addr_o(addr),
      .wr_o(wr_s), .rd_o(rd_s), .wdata_o(wd));
   rtes_event_status rtes_event_status_i (.clk_sys_i(clk), .resetn_i(rst_n),
      .reg_addr_i(addr), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wdata_i(wd),
      .reg_rdata_o(rdata), .update_start_i(ev[3]), .update_end_i(ev[0]),
      .alarm_match_i(ev[1]), .periodic_tick_i(ev[2]), .backup_ok_i(ok),
      .osc_wave_i(ow), .rate_wave_i(rw), .buffer_copy_en_o(copy_en),
      .osc_run_o(osc_run), .divider_run_o(div_run), .rate_select_o(rsel),
      .square_wave_pin_o(pin), .irq_n_o(irq_n));
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task final_report;
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      rtes_host_model_i.xfer(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      nm_q.push_back($sformatf("reg_%h", a));
      rtes_host_model_i.xfer(1'b0, a, 8'h00);
   endtask
   task pulse(input logic [3:0] v);
      @(posedge clk);
      #1 ev = v;
      @(posedge clk);
      #1 ev = 4'h0;
   endtask
   // Read data is registered, so compare one edge after the strobe
   always @(posedge clk) begin
      if (rd_d) chk(nm_q.pop_front(), exp_q.pop_front(), rdata);
      rd_d <= rd_s;
   end
   initial begin
      #400000 miscompares++;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("copy_en", 8'h01, 8'(copy_en));
      chk("run_rate", 8'h00, 8'({osc_run, div_run, rsel}));
      rd(8'h0d, 8'h80);
      ok = 1'b0;
      wr(8'h0d, 8'hff);
      rd(8'h0d, 8'h00);
      rd(8'h33, 8'h00);
      wr(8'h0a, 8'h26);
      chk("run_rate", 8'h36, 8'({osc_run, div_run, rsel}));
      wr(8'h0c, 8'hff);
      rd(8'h0c, 8'h00);
      wr(8'h0a, 8'h36);
      chk("run_rate", 8'h36, 8'({osc_run, div_run, rsel}));
      wr(8'h0c, 8'hff);
      rd(8'h0c, 8'h04);
      wr(8'h0b, 8'h08);
      for (i = 0; i < 12; i++) begin
         if (i == 4) wr(8'h0a, 8'h26);
         if (i == 8) wr(8'h0b, 8'h00);
         @(posedge clk);
         #1 ow = $random(seed);
         rw = $random(seed);
         pe = i < 4 ? ow : i < 8 ? rw : 1'b0;
         @(posedge clk);
         #1 chk("pin", 8'(pe), 8'(pin));
      end
      rd(8'h0c, 8'h00);
      wr(8'h0b, 8'h70);
      for (i = 0; i < 3; i++) begin
         pulse(4'h1 << i);
         chk("irq_n", 8'h00, 8'(irq_n));
         rd(8'h0c, 8'h80 | (8'h10 << i));
         rd(8'h0c, 8'h00);
         chk("irq_n", 8'h01, 8'(irq_n));
      end
      // A request outlives the enable that raised it
      pulse(4'h2);
      wr(8'h0b, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk("irq_n", 8'h00, 8'(irq_n));
      rd(8'h0c, 8'ha0);
      chk("irq_n", 8'h01, 8'(irq_n));
      pulse(4'h2);
      chk("irq_n", 8'h01, 8'(irq_n));
      rd(8'h0c, 8'h20);
      pulse(4'h8);
      rd(8'h0a, 8'ha6);
      wr(8'h0b, 8'h90);
      rd(8'h0b, 8'h80);
      chk("copy_en", 8'h00, 8'(copy_en));
      rd(8'h0a, 8'h26);
      pulse(4'h8);
      rd(8'h0a, 8'h26);
      wr(8'h0b, 8'h00);
      pulse(4'h8);
      rd(8'h0a, 8'ha6);
      pulse(4'h1);
      rd(8'h0a, 8'h26);
      rd(8'h0c, 8'h10);
      wr(8'h0a, 8'h65);
      chk("run_rate", 8'h25, 8'({osc_run, div_run, rsel}));
      repeat (3) @(posedge clk);
      final_report;
   end
endmodule
`default_nettype wire

// ---- bench/rtes_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtes_host_model (
   // Clock
   input wire logic clk_i,
   // Register port
   output logic [7:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] wdata_o
);
   initial begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
   end
   // One strobe cycle; released data inverted so stale values never match
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      @(posedge clk_i);
      #1 addr_o = a;
      wdata_o = d;
      wr_o = w;
      rd_o = !w;
      @(posedge clk_i);
      #1 wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
endmodule
`default_nettype wire

// ---- verilog/rtes_defines.vh ----
`ifndef RTES_DEFINES_VH
`define RTES_DEFINES_VH
// Register indices on the multiplexed bus
`define RTES_ADDR_CTRL_A 8'h0a
`define RTES_ADDR_CTRL_B 8'h0b
`define RTES_ADDR_EVENT 8'h0c
`define RTES_ADDR_INTEG 8'h0d
// Rate/oscillator register fields
`define RTES_A_PEND_BIT 7
`define RTES_A_OSC_HI 6
`define RTES_A_OSC_LO 4
`define RTES_A_RATE_HI 3
`define RTES_A_RATE_LO 0
`define RTES_OSC_RUN 3'b010
`define RTES_OSC_RUN_WR 3'b011
// Control register fields
`define RTES_B_INHIBIT_BIT 7
`define RTES_B_PIE_BIT 6
`define RTES_B_AIE_BIT 5
`define RTES_B_UIE_BIT 4
`define RTES_B_SQUARE_OUT_EN_BIT 3
// Event status fields
`define RTES_C_IRQ_BIT 7
`define RTES_C_PF_BIT 6
`define RTES_C_AF_BIT 5
`define RTES_C_UF_BIT 4
`define RTES_C_FAST_BIT 2
// Integrity status field
`define RTES_D_VALID_BIT 7
// Reset values
`define RTES_A_RESET 8'h00
`define RTES_B_RESET 8'h00
`endif

// ---- verilog/rtes_event_status.v ----
// What this block does
// - Inhibit stops buffer copy, clears update enable
// - Event status read-only except fast enable
// - Event status bits 0,1,3 read zero
// - Fast enable settable only under pattern 011
// - Other oscillator pattern clears fast enable
// - Both enables drive raw oscillator on pin
// - Update completion sets update flag
// - Alarm match sets alarm flag
// - Periodic tick sets periodic flag
// - Interrupt flag from enabled event flags
// - Event status read clears four flags
// - Integrity register read-only, low bits zero
// - Bit 7 reports backup source valid
// - Pattern 011 runs like 010, adds writes
// - Inhibit holds update pending cleared
// - Square output disabled held low
`timescale 1ns/100ps
`default_nettype none
`include "rtes_defines.vh"
module rtes_event_status #(
   parameter ADDR_W = 8
) (
   // Clock and reset
   input wire clk_sys_i,
   input wire resetn_i,
   // Register port, one-cycle strobes
   input wire [ADDR_W-1:0] reg_addr_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_wdata_i,
   output wire [7:0] reg_rdata_o,
   // Events from timekeeping core
   input wire update_start_i,
   input wire update_end_i,
   input wire alarm_match_i,
   input wire periodic_tick_i,
   input wire backup_ok_i,
   input wire osc_wave_i,
   input wire rate_wave_i,
   // Controls to timekeeping core
   output wire buffer_copy_en_o,
   output wire osc_run_o,
   output wire divider_run_o,
   output wire [3:0] rate_select_o,
   // Pins
   output wire square_wave_pin_o,
   output wire irq_n_o
);
   reg [2:0] osc_ctrl_r;
   reg [3:0] rate_select_r;
   reg update_pending_r;
   reg transfer_inhibit_r;
   reg periodic_irq_en_r;
   reg alarm_irq_en_r;
   reg update_done_irq_en_r;
   reg square_out_en_r;
   reg [2:0] ctrl_b_low_r;
   reg fast_clock_out_en_r;
   reg [7:0] rdata_r;
   reg [7:0] rdata_nxt;
   reg irq_n_r;
   wire sel_a;
   wire sel_b;
   wire sel_c;
   wire sel_d;
   wire event_rd;
   wire periodic_flag;
   wire alarm_flag;
   wire update_done_flag;
   wire irq_request_flag;
   wire irq_set;
   wire writable_c;

   assign sel_a = (reg_addr_i == `RTES_ADDR_CTRL_A);
   assign sel_b = (reg_addr_i == `RTES_ADDR_CTRL_B);
   assign sel_c = (reg_addr_i == `RTES_ADDR_EVENT);
   assign sel_d = (reg_addr_i == `RTES_ADDR_INTEG);
   assign event_rd = reg_rd_i & sel_c;
   // Pattern 011 still runs oscillator and divider
   assign writable_c = (osc_ctrl_r == `RTES_OSC_RUN_WR);

   // Rate/oscillator register
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         osc_ctrl_r <= 3'h0;
         rate_select_r <= 4'h0;
      end else if (reg_wr_i && sel_a) begin
         osc_ctrl_r <= reg_wdata_i[`RTES_A_OSC_HI:`RTES_A_OSC_LO];
         rate_select_r <= reg_wdata_i[`RTES_A_RATE_HI:`RTES_A_RATE_LO];
      end
   end

   // Pending bit is status only; writes never reach it
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i)
         update_pending_r <= 1'b0;
      else if (transfer_inhibit_r)
         update_pending_r <= 1'b0;
      else if (update_start_i)
         update_pending_r <= 1'b1;
      else if (update_end_i)
         update_pending_r <= 1'b0;
   end

   // Control register
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         transfer_inhibit_r <= 1'b0;
         periodic_irq_en_r <= 1'b0;
         alarm_irq_en_r <= 1'b0;
         update_done_irq_en_r <= 1'b0;
         square_out_en_r <= 1'b0;
         ctrl_b_low_r <= 3'h0;
      end else begin
         if (reg_wr_i && sel_b) begin
            transfer_inhibit_r <= reg_wdata_i[`RTES_B_INHIBIT_BIT];
            periodic_irq_en_r <= reg_wdata_i[`RTES_B_PIE_BIT];
            alarm_irq_en_r <= reg_wdata_i[`RTES_B_AIE_BIT];
            square_out_en_r <= reg_wdata_i[`RTES_B_SQUARE_OUT_EN_BIT];
            ctrl_b_low_r <= reg_wdata_i[2:0];
         end
         // Inhibit in force or being written forces enable off
         if (transfer_inhibit_r ||
             (reg_wr_i && sel_b && reg_wdata_i[`RTES_B_INHIBIT_BIT]))
            update_done_irq_en_r <= 1'b0;
         else if (reg_wr_i && sel_b)
            update_done_irq_en_r <= reg_wdata_i[`RTES_B_UIE_BIT];
      end
   end
   assign buffer_copy_en_o = ~transfer_inhibit_r;

   // Fast clock enable; only writable event bit
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i)
         fast_clock_out_en_r <= 1'b0;
      else if (reg_wr_i && sel_a &&
               reg_wdata_i[`RTES_A_OSC_HI:`RTES_A_OSC_LO] !=
               `RTES_OSC_RUN_WR)
         fast_clock_out_en_r <= 1'b0;
      else if (reg_wr_i && sel_c && writable_c)
         fast_clock_out_en_r <= reg_wdata_i[`RTES_C_FAST_BIT];
   end

   // Event flags
   rtes_sticky u_update_flag (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .set_i(update_end_i),
      .clr_i(event_rd),
      .flag_o(update_done_flag)
   );
   rtes_sticky u_alarm_flag (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .set_i(alarm_match_i),
      .clr_i(event_rd),
      .flag_o(alarm_flag)
   );
   rtes_sticky u_periodic_flag (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .set_i(periodic_tick_i),
      .clr_i(event_rd),
      .flag_o(periodic_flag)
   );
   // Request uses the next flag values so a new event survives a read
   assign irq_set = (alarm_irq_en_r & (alarm_match_i | (alarm_flag &
                     ~event_rd))) |
                    (periodic_irq_en_r & (periodic_tick_i |
                     (periodic_flag & ~event_rd))) |
                    (update_done_irq_en_r & (update_end_i |
                     (update_done_flag & ~event_rd)));
   rtes_sticky u_irq_flag (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .set_i(irq_set),
      .clr_i(event_rd),
      .flag_o(irq_request_flag)
   );

   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i)
         irq_n_r <= 1'b1;
      else
         // Tracks the flag, so a dropped enable leaves the pin low
         irq_n_r <= ~(irq_set | (irq_request_flag & ~event_rd));
   end
   assign irq_n_o = irq_n_r;

   // Read data, captured on the read strobe
   always @* begin
      rdata_nxt = 8'h00;
      if (sel_a) begin
         // Gate covers the cycle before the clear lands
         rdata_nxt[`RTES_A_PEND_BIT] = update_pending_r &
                                       ~transfer_inhibit_r;
         rdata_nxt[`RTES_A_OSC_HI:`RTES_A_OSC_LO] = osc_ctrl_r;
         rdata_nxt[`RTES_A_RATE_HI:`RTES_A_RATE_LO] = rate_select_r;
      end else if (sel_b) begin
         rdata_nxt = {transfer_inhibit_r, periodic_irq_en_r,
                      alarm_irq_en_r, update_done_irq_en_r,
                      square_out_en_r, ctrl_b_low_r};
      end else if (sel_c) begin
         // Bits 0, 1, 3 stay zero
         rdata_nxt[`RTES_C_IRQ_BIT] = irq_request_flag;
         rdata_nxt[`RTES_C_PF_BIT] = periodic_flag;
         rdata_nxt[`RTES_C_AF_BIT] = alarm_flag;
         rdata_nxt[`RTES_C_UF_BIT] = update_done_flag;
         rdata_nxt[`RTES_C_FAST_BIT] = fast_clock_out_en_r;
      end else if (sel_d) begin
         rdata_nxt[`RTES_D_VALID_BIT] = backup_ok_i;
      end
   end
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i)
         rdata_r <= 8'h00;
      else if (reg_rd_i)
         rdata_r <= rdata_nxt;
   end
   assign reg_rdata_o = rdata_r;

   assign osc_run_o = (osc_ctrl_r == `RTES_OSC_RUN) | writable_c |
                      (osc_ctrl_r[2:1] == 2'b11);
   assign divider_run_o = (osc_ctrl_r == `RTES_OSC_RUN) | writable_c;
   assign rate_select_o = rate_select_r;

   rtes_square_out u_square (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .square_out_en_i(square_out_en_r),
      .fast_clock_out_en_i(fast_clock_out_en_r),
      .osc_wave_i(osc_wave_i),
      .rate_wave_i(rate_wave_i),
      .square_wave_pin_o(square_wave_pin_o)
   );
endmodule
`default_nettype wire

// ---- verilog/rtes_square_out.v ----
`timescale 1ns/100ps
`default_nettype none
// Square-wave pin source selection, registered
module rtes_square_out (
   // Clock and reset
   input wire clk_sys_i,
   input wire resetn_i,
   // Sources
   input wire square_out_en_i,
   input wire fast_clock_out_en_i,
   input wire osc_wave_i,
   input wire rate_wave_i,
   // Pin
   output wire square_wave_pin_o
);
   reg pin_r;
   reg pin_nxt;
   always @* begin
      pin_nxt = 1'b0;
      if (square_out_en_i) begin
         if (fast_clock_out_en_i)
            pin_nxt = osc_wave_i;
         else
            pin_nxt = rate_wave_i;
      end
      // Otherwise held low
   end
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i)
         pin_r <= 1'b0;
      else
         pin_r <= pin_nxt;
   end
   assign square_wave_pin_o = pin_r;
endmodule
`default_nettype wire

// ---- verilog/rtes_sticky.v ----
`timescale 1ns/100ps
`default_nettype none
// One sticky flag; a set in the clearing cycle wins
module rtes_sticky (
   // Clock and reset
   input wire clk_sys_i,
   input wire resetn_i,
   // Control
   input wire set_i,
   input wire clr_i,
   // Flag
   output wire flag_o
);
   reg flag_r;
   wire flag_nxt;
   assign flag_nxt = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_r);
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i)
         flag_r <= 1'b0;
      else
         flag_r <= flag_nxt;
   end
   assign flag_o = flag_r;
endmodule
`default_nettype wire
